// ### logic/adc_control_registers.sv
// Purpose: converter control registers and the logic they steer
// Assumes: core and DMA signals share clk; Wishbone classic slave
// Notes: field positions and masks come from the package
// Operation
// - build mode: 1 sequential DMA addresses, 0 scatter/gather by channel.
// - resolution select: 1 gives 12-bit one channel, 0 10-bit up to four channels.
// - output format field shapes each result: four layouts, both resolutions.
// - reference field picks high and low references; 1xx acts as 000.
// - channel count: 00 channel 0, 01 channels 0-1, 1x channels 0-3.
// - fill status shows which buffer half fills, only with buffer split.
// - without DMA, interrupt every N+1 conversions, N from low four rate bits.
// - with DMA, pulse dma_advance every N+1 conversions, N the full rate field.
`timescale 1ns/1ps
module adc_control_registers
	import adc_ctrl_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int SLOT_W = 4
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// converter core
	input wire logic device_idle,
	input wire logic sample_end,
	input wire logic conv_done,
	input wire logic [11:0] conv_result,
	input wire logic [1:0] conv_channel,
	output logic converter_run,
	output logic res12_mode,
	output logic sample_active,
	output logic [3:0] trigger_setup,
	output logic [3:0] channel_enable,
	output logic vref_high_ext,
	output logic vref_low_ext,
	output logic buffer_fill_status,
	output logic [15:0] result_word,
	output logic result_valid,
	// dma and interrupt requests
	output logic [ADDR_W-1:0] dma_addr,
	output logic dma_write,
	output logic dma_advance,
	output logic conv_irq
);
	////////////////////////////////////////////////////////////////////////////
	// registers and wires
	logic [15:0] one_reg, one_next;
	logic [15:0] two_reg, two_next;
	logic dma_en_reg, dma_en_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [4:0] cnt_reg, cnt_next;
	logic fill_reg, fill_next;
	logic [ADDR_W-1:0] seq_reg, seq_next;
	logic [SLOT_W-1:0] slot_reg, slot_next;
	logic run_reg, run_next;
	logic res_reg, res_next;
	logic sample_control_reg, sample_control_next;
	logic [3:0] trig_reg, trig_next;
	logic [3:0] chen_reg, chen_next;
	logic vh_reg, vh_next, vl_reg, vl_next;
	logic [15:0] word_reg, word_next;
	logic valid_reg, valid_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic dwr_reg, dwr_next, adv_reg, adv_next, irq_reg, irq_next;
	logic req, wr_commit, running, counted, interval_hit;
	logic [4:0] limit;
	logic [15:0] bmask, one_rd, two_rd;
	adc_result_if res_if ();

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_commit = req & wb_we_i & ack_reg; // write lands on the acked edge
	assign bmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign running = one_reg[ON_BIT] & ~(one_reg[IDLE_STOP_BIT] & device_idle);
	assign counted = conv_done & running;

	// read views with unimplemented and hidden fields zeroed
	always_comb begin
		one_rd = one_reg & (CTRL_ONE_WMASK | 16'h0001);
		two_rd = two_reg & CTRL_TWO_WMASK;
		two_rd[FILL_BIT] = fill_reg;
		if (one_reg[RES_BIT]) begin
			two_rd[CHAN_LSB +: 2] = 2'h0;
		end
	end

	// answer one cycle after the request, drop ack the cycle after
	always_comb begin
		ack_next = req & ~ack_reg;
		rdat_next = 32'h0000_0000;
		if (req & ~ack_reg & ~wb_we_i) begin
			unique case (wb_adr_i)
				CTRL_ONE_OFFSET: rdat_next = {16'h0000, one_rd};
				CTRL_TWO_OFFSET: rdat_next = {16'h0000, two_rd};
				DMA_CFG_OFFSET: rdat_next = {31'h0, dma_en_reg};
				default: rdat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register state
	always_comb begin
		one_next = one_reg;
		two_next = two_reg;
		dma_en_next = dma_en_reg;
		if (wr_commit && wb_adr_i == CTRL_ONE_OFFSET) begin
			one_next = (one_reg & ~(bmask & CTRL_ONE_WMASK)) | (wb_dat_i[15:0] & bmask & CTRL_ONE_WMASK);
			// software can only clear done, writing one is ignored
			if (bmask[DONE_BIT] & ~wb_dat_i[DONE_BIT]) begin
				one_next[DONE_BIT] = 1'b0;
			end
		end
		if (wr_commit && wb_adr_i == CTRL_TWO_OFFSET) begin
			two_next = (two_reg & ~(bmask & CTRL_TWO_WMASK)) | (wb_dat_i[15:0] & bmask & CTRL_TWO_WMASK);
			if (one_reg[RES_BIT]) begin
				two_next[CHAN_LSB +: 2] = two_reg[CHAN_LSB +: 2];
			end
		end
		if (wr_commit && wb_adr_i == DMA_CFG_OFFSET && wb_sel_i[0]) begin
			dma_en_next = wb_dat_i[0];
		end
		// hardware clears sample at conversion start, clears done on new sample
		if (sample_end) begin
			one_next[SAMPLE_BIT] = 1'b0;
		end
		if (one_reg[AUTO_BIT] & counted) begin
			one_next[SAMPLE_BIT] = 1'b1;
		end else if (~one_reg[SAMPLE_BIT] & one_next[SAMPLE_BIT]) begin
			one_next[DONE_BIT] = 1'b0;
		end
		// set wins over any clear in the same cycle
		if (counted) begin
			one_next[DONE_BIT] = 1'b1;
		end
		// judged on the new value so one write may switch on and start sampling
		if (~one_next[ON_BIT]) begin
			one_next[SAMPLE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			one_reg <= CTRL_ONE_RESET;
			two_reg <= CTRL_TWO_RESET;
			dma_en_reg <= 1'b0;
		end else begin
			one_reg <= one_next;
			two_reg <= two_next;
			dma_en_reg <= dma_en_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion interval counter, fill status and dma addressing
	assign limit = dma_en_reg ? two_reg[RATE_LSB +: 5] : {1'b0, two_reg[RATE_LSB +: 4]};
	assign interval_hit = counted & (cnt_reg >= limit);

	always_comb begin
		cnt_next = cnt_reg;
		fill_next = fill_reg;
		seq_next = seq_reg;
		slot_next = slot_reg;
		addr_next = addr_reg;
		dwr_next = 1'b0;
		irq_next = 1'b0;
		adv_next = 1'b0;
		if (counted) begin
			cnt_next = interval_hit ? 5'h00 : cnt_reg + 5'h01;
			dwr_next = dma_en_reg;
			if (one_reg[BUILD_MODE_BIT]) begin
				addr_next = seq_reg;
			end else begin
				addr_next = ADDR_W'({conv_channel, slot_reg});
			end
			if (one_reg[BUILD_MODE_BIT] & dma_en_reg) begin
				seq_next = seq_reg + ADDR_W'(1);
			end
		end
		if (interval_hit) begin
			irq_next = ~dma_en_reg;
			adv_next = dma_en_reg;
			if (dma_en_reg & ~one_reg[BUILD_MODE_BIT]) begin
				slot_next = slot_reg + SLOT_W'(1);
			end
			fill_next = two_reg[SPLIT_BIT] & ~fill_reg;
		end
		if (~two_reg[SPLIT_BIT]) begin
			fill_next = 1'b0;
		end
		if (~one_reg[ON_BIT]) begin
			cnt_next = 5'h00;
			seq_next = '0;
			slot_next = '0;
			fill_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg <= 5'h00;
			fill_reg <= 1'b0;
			seq_reg <= '0;
			slot_reg <= '0;
			addr_reg <= '0;
			dwr_reg <= 1'b0;
			irq_reg <= 1'b0;
			adv_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fill_reg <= fill_next;
			seq_reg <= seq_next;
			slot_reg <= slot_next;
			addr_reg <= addr_next;
			dwr_reg <= dwr_next;
			irq_reg <= irq_next;
			adv_reg <= adv_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result formatting
	assign res_if.raw = conv_result;
	assign res_if.format = one_reg[FORMAT_LSB +: 2];
	assign res_if.res12 = one_reg[RES_BIT];

	adc_result_format u_format (
		.res(res_if.fmt)
	);

	////////////////////////////////////////////////////////////////////////////
	// decoded settings driven to the converter core
	always_comb begin
		run_next = running;
		res_next = one_reg[RES_BIT];
		sample_control_next = one_reg[SAMPLE_BIT];
		trig_next = one_reg[TRIG_LSB +: 4];
		word_next = counted ? res_if.word : word_reg;
		valid_next = counted;
		vh_next = 1'b0;
		vl_next = 1'b0;
		unique case (two_reg[REF_LSB +: 3])
			REF_EXT_HIGH: vh_next = 1'b1;
			REF_EXT_LOW: vl_next = 1'b1;
			REF_EXT_BOTH: begin
				vh_next = 1'b1;
				vl_next = 1'b1;
			end
			default: begin
				vh_next = 1'b0;
				vl_next = 1'b0;
			end
		endcase
		if (one_reg[RES_BIT]) begin
			chen_next = 4'h1;
		end else if (two_reg[CHAN_LSB + 1]) begin
			chen_next = 4'hF;
		end else if (two_reg[CHAN_LSB]) begin
			chen_next = 4'h3;
		end else begin
			chen_next = 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_reg <= 1'b0;
			res_reg <= 1'b0;
			sample_control_reg <= 1'b0;
			trig_reg <= 4'h0;
			chen_reg <= 4'h1;
			vh_reg <= 1'b0;
			vl_reg <= 1'b0;
			word_reg <= 16'h0000;
			valid_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			res_reg <= res_next;
			sample_control_reg <= sample_control_next;
			trig_reg <= trig_next;
			chen_reg <= chen_next;
			vh_reg <= vh_next;
			vl_reg <= vl_next;
			word_reg <= word_next;
			valid_reg <= valid_next;
		end
	end

	// outputs straight from flops
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign converter_run = run_reg;
	assign res12_mode = res_reg;
	assign sample_active = sample_control_reg;
	assign trigger_setup = trig_reg;
	assign channel_enable = chen_reg;
	assign vref_high_ext = vh_reg;
	assign vref_low_ext = vl_reg;
	assign buffer_fill_status = fill_reg;
	assign result_word = word_reg;
	assign result_valid = valid_reg;
	assign dma_addr = addr_reg;
	assign dma_write = dwr_reg;
	assign dma_advance = adv_reg;
	assign conv_irq = irq_reg;
endmodule

// ### logic/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter control register block
// Assumes: registers sit in the low 16 bits of a 32-bit classic Wishbone word
// Notes: bit positions and masks are given once here and used by name
package adc_ctrl_pkg;
	// word byte offsets
	localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_TWO_OFFSET = 8'h04;
	localparam logic [7:0] DMA_CFG_OFFSET = 8'h08;
	// reset values
	localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
	localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
	// writable bit masks, unimplemented positions are zero
	localparam logic [15:0] CTRL_ONE_WMASK = 16'hB7FE;
	localparam logic [15:0] CTRL_TWO_WMASK = 16'hE77F;
	// control register one fields
	localparam int ON_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int BUILD_MODE_BIT = 12;
	localparam int RES_BIT = 10;
	localparam int FORMAT_LSB = 8;
	localparam int TRIG_LSB = 4;
	localparam int SIMUL_BIT = 3;
	localparam int AUTO_BIT = 2;
	localparam int SAMPLE_BIT = 1;
	localparam int DONE_BIT = 0;
	// control register two fields
	localparam int REF_LSB = 13;
	localparam int SCAN_BIT = 10;
	localparam int CHAN_LSB = 8;
	localparam int FILL_BIT = 7;
	localparam int RATE_LSB = 2;
	localparam int SPLIT_BIT = 1;
	localparam int ALT_BIT = 0;
	// output format codes
	localparam logic [1:0] FMT_UINT = 2'h0;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_FRAC = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;
	// reference codes
	localparam logic [2:0] REF_EXT_HIGH = 3'h1;
	localparam logic [2:0] REF_EXT_LOW = 3'h2;
	localparam logic [2:0] REF_EXT_BOTH = 3'h3;
endpackage

// ### logic/adc_result_format.sv
// Purpose: shapes a 10- or 12-bit result into the 16-bit output word
// Assumes: raw result is right-aligned in raw
// Notes: combinational, registered by the caller
`timescale 1ns/1ps
module adc_result_format
	import adc_ctrl_pkg::*;
(
	// result path
	adc_result_if.fmt res
);
	logic s10;
	logic s12;

	// sign bit is the inverted result msb
	assign s10 = ~res.raw[9];
	assign s12 = ~res.raw[11];

	// select layout by resolution and format code
	always_comb begin
		res.word = 16'h0000;
		if (res.res12) begin
			unique case (res.format)
				FMT_SFRAC: res.word = {s12, res.raw[10:0], 4'h0};
				FMT_FRAC: res.word = {res.raw[11:0], 4'h0};
				FMT_SINT: res.word = {{5{s12}}, res.raw[10:0]};
				FMT_UINT: res.word = {4'h0, res.raw[11:0]};
			endcase
		end else begin
			unique case (res.format)
				FMT_SFRAC: res.word = {s10, res.raw[8:0], 6'h00};
				FMT_FRAC: res.word = {res.raw[9:0], 6'h00};
				FMT_SINT: res.word = {{7{s10}}, res.raw[8:0]};
				FMT_UINT: res.word = {6'h00, res.raw[9:0]};
			endcase
		end
	end
endmodule

// ### logic/adc_result_if.sv
// Purpose: carries a raw result and its format settings to the formatter
// Assumes: one clock domain, purely combinational path
// Notes: ctrl side drives raw data and settings, fmt side returns the word
`timescale 1ns/1ps
interface adc_result_if;
	logic [11:0] raw;
	logic [1:0] format;
	logic res12;
	logic [15:0] word;
	// formatter end
	modport fmt (input raw, input format, input res12, output word);
	// control end
	modport ctrl (output raw, output format, output res12, input word);
endinterface

// ### verif/adc_control_registers_monitor.sv
// Purpose: port checker for the converter control block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module adc_control_registers_monitor (
	// clock and bus
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	// core side
	input wire logic device_idle,
	input wire logic sample_end,
	input wire logic conv_done,
	input wire logic converter_run,
	input wire logic res12_mode,
	input wire logic sample_active,
	input wire logic [3:0] channel_enable,
	input wire logic result_valid,
	input wire logic dma_write,
	input wire logic dma_advance,
	input wire logic conv_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// bus answer timing
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	// channel selection
	property p_chan_res12;
		res12_mode |-> channel_enable == 4'h1;
	endproperty
	a_chan_res12: assert property (p_chan_res12) else $error("channels wrong in 12-bit mode");
	property p_chan_legal;
		channel_enable inside {4'h1, 4'h3, 4'hF};
	endproperty
	a_chan_legal: assert property (p_chan_legal) else $error("illegal channel set");
	// conversion events
	property p_irq_valid;
		conv_irq |-> result_valid && !dma_advance && !dma_write;
	endproperty
	a_irq_valid: assert property (p_irq_valid) else $error("interrupt without result");
	property p_adv_valid;
		dma_advance |-> result_valid && dma_write;
	endproperty
	a_adv_valid: assert property (p_adv_valid) else $error("address advance without write");
	property p_valid_cause;
		!conv_done |=> !result_valid;
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("result without conversion");
	property p_off_ignored;
		conv_done && !converter_run && !$past(wb_ack_o) && $stable(device_idle) |=> !result_valid;
	endproperty
	a_off_ignored: assert property (p_off_ignored) else $error("conversion taken while stopped");
	property p_sample_end;
		sample_end && !conv_done && !(wb_cyc_i && wb_we_i) |-> ##[1:2] !sample_active;
	endproperty
	a_sample_end: assert property (p_sample_end) else $error("sample bit not cleared");
	// main scenarios
	c_irq: cover property (conv_irq);
	c_adv: cover property (dma_advance);
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind adc_control_registers adc_control_registers_monitor i_adc_control_registers_monitor (.*);

// ### verif/adc_control_registers_test.sv
// Purpose: self-checking bench for the converter control block
// Assumes: classic Wishbone master, core model on the far side
// Notes: expectations come from field layouts and format rules
`timescale 1ns/1ps
module adc_control_registers_test;
	import adc_ctrl_pkg::*;
	logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, device_idle;
	logic [7:0] wb_adr_i, dma_addr, prev;
	logic [3:0] wb_sel_i, trigger_setup, channel_enable;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic sample_end, conv_done, converter_run, res12_mode, sample_active, vref_high_ext, vref_low_ext;
	logic buffer_fill_status, result_valid, dma_write, dma_advance, conv_irq, dma, hit, fill;
	logic [11:0] conv_result;
	logic [1:0] conv_channel;
	logic [15:0] result_word, rd;
	logic [4:0] rates [4] = '{5'h13, 5'h0F, 5'h01, 5'h1F};
	int error_cnt, checks, cycles, nn;
	adc_control_registers i_adc_control_registers (.*);
	adc_core_model i_adc_core_model (.*);
	////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	// verdict
	task automatic final_report();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one classic cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, d};
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// second edge lets registered settings follow the write
		repeat (2) @(posedge clk);
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		check(n, rd, e);
	endtask
	task automatic conv(input logic [11:0] raw, input logic [1:0] ch);
		i_adc_core_model.convert(raw, ch);
		@(posedge clk);
	endtask
	// expected output word
	function automatic logic [15:0] fmt(input logic r12, input logic [1:0] f, input logic [11:0] raw);
		logic [15:0] u, fr;
		logic msb;
		u = r12 ? {4'h0, raw} : {6'h00, raw[9:0]};
		fr = r12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
		msb = r12 ? raw[11] : raw[9];
		case (f)
			2'h0: return u;
			2'h1: return msb ? (u & (r12 ? 16'h07FF : 16'h01FF)) : (u | (r12 ? 16'hF800 : 16'hFE00));
			2'h2: return fr;
			default: return fr ^ 16'h8000;
		endcase
	endfunction
	////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, device_idle} = 4'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("chan_en", channel_enable, 16'h0001);
		rdchk("ctrl_one", CTRL_ONE_OFFSET, CTRL_ONE_RESET);
		rdchk("ctrl_two", CTRL_TWO_OFFSET, CTRL_TWO_RESET);
		bus(1'b1, 8'h0C, 16'hFFFF);
		rdchk("unmapped", 8'h0C, 16'h0000);
		bus(1'b1, CTRL_ONE_OFFSET, 16'hFFFF);
		rdchk("ctrl_one", CTRL_ONE_OFFSET, 16'hB7FE);
		bus(1'b1, CTRL_TWO_OFFSET, 16'hFFFF);
		rdchk("ctrl_two", CTRL_TWO_OFFSET, 16'hE47F);
		check("run", converter_run, 16'h0001);
		check("res12", res12_mode, 16'h0001);
		check("trig", trigger_setup, 16'h000F);
		check("vref", {vref_high_ext, vref_low_ext}, 16'h0000);
		// reference and channel count codes in 10-bit mode
		bus(1'b1, CTRL_ONE_OFFSET, 16'h8000);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, CTRL_TWO_OFFSET, {i[2:0], 3'b000, i[1:0], 8'h00});
			check("chan_en", channel_enable, i[1] ? 16'hF : (i[0] ? 16'h3 : 16'h1));
			check("vref", {vref_high_ext, vref_low_ext}, (i == 3) ? 3 : (i == 1) ? 2 : (i == 2) ? 1 : 0);
		end
		// every format in both resolutions, interrupt each time
		bus(1'b1, CTRL_TWO_OFFSET, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, CTRL_ONE_OFFSET, {5'b10000, i[2:0], 8'h00});
			conv(12'h2A5, 2'h0);
			check("word", result_word, fmt(i[2], i[1:0], 12'h2A5));
			check("irq", conv_irq, 16'h0001);
		end
		rdchk("ctrl_one", CTRL_ONE_OFFSET, 16'h8701);
		bus(1'b1, CTRL_ONE_OFFSET, 16'h8700);
		rdchk("ctrl_one", CTRL_ONE_OFFSET, 16'h8700);
		bus(1'b1, CTRL_ONE_OFFSET, 16'h8002);
		check("sample", sample_active, 16'h0001);
		i_adc_core_model.end_sample();
		rdchk("ctrl_one", CTRL_ONE_OFFSET, 16'h8000);
		check("sample", sample_active, 16'h0000);
		// stop while idle
		bus(1'b1, CTRL_ONE_OFFSET, 16'hA000);
		device_idle <= 1'b1;
		repeat (2) @(posedge clk);
		check("run", converter_run, 16'h0000);
		conv(12'h155, 2'h0);
		check("valid", result_valid, 16'h0000);
		device_idle <= 1'b0;
		// interval counts in both DMA modes, sequential addresses, then gather by channel
		for (int c = 0; c < 4; c++) begin
			dma = c[1];
			nn = dma ? rates[c] : {1'b0, rates[c][3:0]};
			fill = 1'b0;
			bus(1'b1, CTRL_ONE_OFFSET, 16'h0000);
			bus(1'b1, CTRL_TWO_OFFSET, {9'h000, rates[c], 2'b10});
			bus(1'b1, DMA_CFG_OFFSET, {15'h0000, dma});
			bus(1'b1, CTRL_ONE_OFFSET, (c == 3) ? 16'h8000 : 16'h9000); // last pass gathers by channel
			for (int k = 0; k < 2 * (nn + 1); k++) begin
				conv(12'h0F0, k[1:0]);
				hit = ((k + 1) % (nn + 1)) == 0;
				fill = fill ^ hit;
				check("irq", conv_irq, hit && !dma);
				check("advance", dma_advance, hit && dma);
				check("fill", buffer_fill_status, fill);
				check("dma_wr", dma_write, dma);
				if (c == 3) check("addr", dma_addr, {10'h000, k[1:0], 4'(k / (nn + 1))});
				else if (dma && k > 0) check("addr", dma_addr, 8'(prev + 8'h01));
				prev = dma_addr;
			end
		end
		final_report();
	end
endmodule

// ### verif/adc_core_model.sv
// Purpose: behavioural analog core feeding the control block
// Assumes: shares clk with the block
// Notes: result lines hold no stale value between conversions
`timescale 1ns/1ps
module adc_core_model (
	// clock
	input wire logic clk,
	// core outputs
	output logic sample_end,
	output logic conv_done,
	output logic [11:0] conv_result,
	output logic [1:0] conv_channel
);
	// idle levels
	initial begin
		sample_end = 1'b0;
		conv_done = 1'b0;
		conv_result = 12'h000;
		conv_channel = 2'h0;
	end
	// one conversion pulse, started just after an edge
	task automatic convert(input logic [11:0] raw, input logic [1:0] ch);
		conv_done <= 1'b1;
		conv_result <= raw;
		conv_channel <= ch;
		@(posedge clk);
		conv_done <= 1'b0;
		conv_result <= ~raw; // inverse so a stale read shows
		conv_channel <= ~ch;
	endtask
	// end of sampling pulse
	task automatic end_sample();
		sample_end <= 1'b1;
		@(posedge clk);
		sample_end <= 1'b0;
	endtask
endmodule
